// >>> assi_pkg.sv
// package for the sequence input select block
// assumes: one clock domain, classic wishbone register access
`default_nettype none
package assi_pkg;
  localparam int          NUM_STEPS      = 8;
  localparam int          SEL_WIDTH      = 2;
  localparam int          STEP_PITCH     = 4;
  localparam int          STEP_IDX_W     = 3;
  localparam logic [7:0]  SEL_REG_OFFSET = 8'h00;
  localparam logic [7:0]  STAT_REG_OFFSET = 8'h04;
  localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
  localparam logic [31:0] SEL_WMASK      = 32'h3333_3333;
  localparam int          ACK_CYCLES     = 1;
  typedef logic [SEL_WIDTH-1:0] assi_chan_t;
endpackage : assi_pkg
`default_nettype wire

// >>> assi_step_if.sv
// interface between register file and step multiplexer
// assumes: both ends on clk_i
`default_nettype none
interface assi_step_if;
  logic [31:0]             sel_word;
  logic [2:0]              step_idx;
  logic                    step_active;
  assi_pkg::assi_chan_t    channel;
  modport regs (output sel_word, output step_idx, output step_active, input channel);
  modport mux  (input sel_word, input step_idx, input step_active, output channel);
endinterface : assi_step_if
`default_nettype wire

// >>> assi_step_mux.sv
// picks the channel field of the running step
// assumes: step index stable while step active
`default_nettype none
module assi_step_mux (
  assi_step_if.mux sif
);
  // field base is step * 4, bits [base+1:base]
  function automatic assi_pkg::assi_chan_t field_of(input logic [31:0] w,
                                                   input logic [2:0] s);
    field_of = w[{s, 2'b00} +: assi_pkg::SEL_WIDTH];
  endfunction

  always_comb begin
    sif.channel = field_of(sif.sel_word, sif.step_idx);
  end
endmodule // assi_step_mux
`default_nettype wire

// >>> assi_top.sv
// sequence input select: register and step to channel routing
// assumes: sequencer drives step index and step active; wishbone classic
//
// Behaviour
// - step eight uses bits 29:28
// - step seven uses bits 25:24
// - step five uses bits 17:16
// - step four uses bits 13:12
// - step three uses bits 9:8
// - step two uses bits 5:4
// - step one uses bits 1:0
// - mux output selects that step's channel
// - reserved pairs read zero, ignore writes
`default_nettype none
module assi_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [2:0]  step_idx_i,
  input  wire logic        step_active_i,
  output logic      [1:0]  mux_channel_o,
  output logic             mux_valid_o
);
  logic [31:0] sequence_input_select_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] rdata_reg;
  logic        req;
  logic        hit_sel;
  logic        hit_stat;
  logic        wr_take;

  assi_step_if sif ();

  // byte enables widened to a bit mask; shared by the write path and its check
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      lane_mask[b*8 +: 8] = {8{sel[b]}};
    end
  endfunction

  assign req      = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign hit_sel  = wb_adr_i == assi_pkg::SEL_REG_OFFSET;
  assign hit_stat = wb_adr_i == assi_pkg::STAT_REG_OFFSET;
  assign wr_take  = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && hit_sel;

  // one-cycle answer; the gap stops a held strobe from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req && (hit_sel || hit_stat);
      err_reg <= req && !(hit_sel || hit_stat);
    end
  end

  // write lands at the ack edge, while the master still holds the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequence_input_select_reg <= assi_pkg::SEL_RESET;
    end else if (wr_take) begin
      sequence_input_select_reg <= (sequence_input_select_reg & ~lane_mask(wb_sel_i))
        | (wb_dat_i & lane_mask(wb_sel_i) & assi_pkg::SEL_WMASK);
    end
  end

  // status word shows the live step and channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (hit_sel) begin
        rdata_reg <= sequence_input_select_reg & assi_pkg::SEL_WMASK;
      end else if (hit_stat) begin
        rdata_reg <= {24'h00_0000, step_active_i, step_idx_i, 2'b00, sif.channel};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  assign sif.sel_word    = sequence_input_select_reg;
  assign sif.step_idx    = step_idx_i;
  assign sif.step_active = step_active_i;

  assi_step_mux u_mux (
    .sif (sif.mux)
  );

  // channel registered so the analog mux sees a clean level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_channel_o <= 2'h0;
      mux_valid_o   <= 1'b0;
    end else begin
      mux_valid_o <= step_active_i;
      if (step_active_i) begin
        mux_channel_o <= sif.channel;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_step(int n);
    step_active_i && step_idx_i == n[2:0];
  endsequence

  property p_step8;
    s_step(7) |=> mux_channel_o == $past(sequence_input_select_reg[29:28]);
  endproperty
  a_step8: assert property (p_step8) else $error("step8 channel wrong");
  property p_step7;
    s_step(6) |=> mux_channel_o == $past(sequence_input_select_reg[25:24]);
  endproperty
  a_step7: assert property (p_step7) else $error("step7 channel wrong");
  property p_step6;
    s_step(5) |=> mux_channel_o == $past(sequence_input_select_reg[21:20]);
  endproperty
  a_step6: assert property (p_step6) else $error("step6 channel wrong");
  property p_step5;
    s_step(4) |=> mux_channel_o == $past(sequence_input_select_reg[17:16]);
  endproperty
  a_step5: assert property (p_step5) else $error("step5 channel wrong");
  property p_step4;
    s_step(3) |=> mux_channel_o == $past(sequence_input_select_reg[13:12]);
  endproperty
  a_step4: assert property (p_step4) else $error("step4 channel wrong");
  property p_step3;
    s_step(2) |=> mux_channel_o == $past(sequence_input_select_reg[9:8]);
  endproperty
  a_step3: assert property (p_step3) else $error("step3 channel wrong");
  property p_step2;
    s_step(1) |=> mux_channel_o == $past(sequence_input_select_reg[5:4]);
  endproperty
  a_step2: assert property (p_step2) else $error("step2 channel wrong");
  property p_step1;
    s_step(0) |=> mux_channel_o == $past(sequence_input_select_reg[1:0]);
  endproperty
  a_step1: assert property (p_step1) else $error("step1 channel wrong");
  property p_hold;
    !step_active_i |=> $stable(mux_channel_o) && !mux_valid_o;
  endproperty
  a_hold: assert property (p_hold) else $error("channel moved while idle");
  property p_resv;
    (sequence_input_select_reg & ~assi_pkg::SEL_WMASK) == 32'h0000_0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  // a write only lands with its ack; lanes left out keep their bits
  sequence s_wr_done;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_sel;
  endsequence
  property p_wr_land;
    s_wr_done |=> sequence_input_select_reg ==
      (($past(sequence_input_select_reg) & ~lane_mask($past(wb_sel_i)))
      | ($past(wb_dat_i) & lane_mask($past(wb_sel_i)) & assi_pkg::SEL_WMASK));
  endproperty
  a_wr_land: assert property (p_wr_land) else $error("select write lost");
  property p_no_stray;
    !(wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_sel)
      |=> $stable(sequence_input_select_reg);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("select changed unasked");
  property p_valid;
    step_active_i |=> mux_valid_o;
  endproperty
  a_valid: assert property (p_valid) else $error("valid missing after step");

  // read path: reserved pairs return zero, fields return what was held
  property p_rd_resv;
    wb_ack_o && !wb_we_i && hit_sel |-> (wb_dat_o & ~assi_pkg::SEL_WMASK) == 32'h0000_0000;
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bits read set");
  property p_rd_value;
    wb_ack_o && !wb_we_i && hit_sel
      |-> wb_dat_o == ($past(sequence_input_select_reg) & assi_pkg::SEL_WMASK);
  endproperty
  a_rd_value: assert property (p_rd_value) else $error("select read wrong");

  sequence s_take_map;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && (hit_sel || hit_stat);
  endsequence
  sequence s_take_bad;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !(hit_sel || hit_stat);
  endsequence
  property p_ack_map;
    s_take_map |=> wb_ack_o && !wb_err_o;
  endproperty
  a_ack_map: assert property (p_ack_map) else $error("mapped access not acked");
  property p_err_bad;
    s_take_bad |=> wb_err_o && !wb_ack_o;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
  property p_dat_hold;
    !(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_we_i) |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");

  // reset itself is checked, so the default disable is switched off here
  property p_reset_clear;
    disable iff (1'b0)
    rst_i |=> sequence_input_select_reg == assi_pkg::SEL_RESET && mux_channel_o == 2'h0
      && !mux_valid_o && !wb_ack_o && !wb_err_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
endmodule // assi_top
`default_nettype wire

// >>> assi_adc_model.sv
// analog input mux model: latches the channel of each valid step
// assumes: channel and valid come registered from the block on clk_i
`default_nettype none
module assi_adc_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] channel_i,
  input  wire logic       valid_i,
  output var  logic [1:0] sampled_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // only a valid step reaches the converter; idle cycles leave the last sample
  always_ff @(posedge clk_i) begin
    if (valid_i) begin
      sampled_o <= channel_i;
    end
  end
endmodule // assi_adc_model
`default_nettype wire

// >>> tb.sv
// bench for the sequence input select block
// assumes: assi_top on one 10 MHz clock, classic wishbone, model on the mux side
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [2:0]  idx   = 3'h0;
  logic        act   = 1'b0;
  logic [31:0] dat_o, rd;
  logic        ack, err, e, vld;
  logic [1:0]  chan, samp;
  int          err_count = 0;
  int          num_checks = 0;
  always #50 clk_i = ~clk_i;
  assi_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .step_idx_i(idx), .step_active_i(act), .mux_channel_o(chan),
    .mux_valid_o(vld));
  assi_adc_model model (.clk_i(clk_i), .channel_i(chan), .valid_i(vld), .sampled_o(samp));
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      test_done();
    end
    rd = dat_o;
    e = err;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({30'h0, chan}, 32'h0);
  endtask
  task automatic t_reserved();
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3333_3333);
    // read-modify-write keeps whatever the reserved pairs returned
    wb(1'b1, 8'h00, rd & 32'hFFFF_FFFC);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3333_3330);
  endtask
  task automatic t_steps(input logic [31:0] p);
    wb(1'b1, 8'h00, p);
    for (int i = 0; i < 8; i++) begin
      idx <= i[2:0];
      act <= 1'b1;
      @(posedge clk_i);
      act <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({30'h0, samp}, {30'h0, p[4*i +: 2]});
      chk({30'h0, chan}, {30'h0, p[4*i +: 2]});
    end
  endtask
  task automatic t_unmapped();
    wb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  // status word while step six runs, status write ignored, then a mid-run reset
  task automatic t_status();
    idx <= 3'h5;
    act <= 1'b1;
    wb(1'b1, 8'h04, 32'hFFFF_FFFF);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_00D2);
    act <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0123_0123);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_reserved();
    t_steps(32'h3210_3210);
    t_steps(32'h0123_0123);
    t_unmapped();
    t_status();
    test_done();
  end
endmodule // tb
`default_nettype wire
